// file: design/sjb_branch_unit.sv
// Branch unit: decodes and executes the signed less-or-equal jump and
// the accumulator-zero jump. Fetch logic offers one instruction at a
// time with escape flag, opcode and displacement already gathered.
// Summary of operation
// RQ1: Signed-le taken when zero or negative differs overflow
// RQ2: Advance PC by two, then add displacement
// RQ3: Signed-le length and states per encoding mode
// RQ4: Not taken continues at advanced PC
// RQ5: Acc-zero jump taken only if accumulator is zero
// RQ6: Accumulator never modified by acc-zero jump
// RQ7: Acc-zero opcode 60h, 2 bytes, 2/5 states
// RQ8: Acc-zero target is advanced PC plus displacement
// RQ9: Displacement sign-extended to PC width
`timescale 1ns/1ps
module sjb_branch_unit
    import sjb_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    input  wire logic              CLK_EN,
    // Instruction offer
    input  wire logic              INSN_VALID,
    input  wire logic              SOURCE_MODE,
    input  wire logic              ESCAPED,
    input  wire logic [7:0]        OPCODE,
    input  wire logic [7:0]        DISP,
    input  wire logic [PC_W-1:0]   PC_IN,
    // Core state
    input  wire logic [DATA_W-1:0] ACC_IN,
    input  wire logic              ZERO_FLAG,
    input  wire logic              NEG_FLAG,
    input  wire logic              OVERFLOW_FLAG,
    // Results
    output logic                   BUSY,
    output logic                   DONE,
    output logic                   DECODED,
    output logic                   TAKEN,
    output logic [PC_W-1:0]        PC_OUT,
    output logic [1:0]             INSN_LEN,
    output logic [2:0]             STATES,
    output logic [DATA_W-1:0]      ACC_OUT
);
    // ****************************************************************
    // Decode
    // ****************************************************************
    sjb_state_t      state;
    logic [2:0]      remain;
    logic            is_sle;
    logic            is_az;
    logic            sle_cond;
    logic            az_cond;
    logic            next_taken;
    logic [PC_W-1:0] next_pc_seq;
    logic [PC_W-1:0] next_target;
    logic [2:0]      next_states;
    logic [1:0]      next_len;

    function automatic logic [PC_W-1:0] sext_disp(
        input logic [DATA_W-1:0] d);
        sext_disp = {{(PC_W-DATA_W){d[DATA_W-1]}}, d}; // RQ9
    endfunction : sext_disp

    // Escape required in binary mode, forbidden in source mode
    assign is_sle = (OPCODE == OPC_SIGNED_LE)
        && (ESCAPED != SOURCE_MODE); // RQ3
    assign is_az    = (OPCODE == OPC_ACC_ZERO) && !ESCAPED; // RQ7
    assign sle_cond = ZERO_FLAG || (NEG_FLAG != OVERFLOW_FLAG); // RQ1
    assign az_cond  = (ACC_IN == '0); // RQ5
    assign next_taken = (is_sle && sle_cond) || (is_az && az_cond);
    assign next_pc_seq = PC_IN + PC_STEP; // RQ2 RQ8
    assign next_target = next_pc_seq + sext_disp(DISP); // RQ2 RQ8 RQ9

    always_comb
    begin
        next_states = ONE_STATE;
        next_len    = LEN_ACC_ZERO;
        if (is_sle && !SOURCE_MODE)
        begin
            next_len    = LEN_SLE_BIN; // RQ3
            next_states = sle_cond ? ST_SLE_BIN_T : ST_SLE_BIN_N;
        end
        else if (is_sle)
        begin
            next_len    = LEN_SLE_SRC; // RQ3
            next_states = sle_cond ? ST_SLE_SRC_T : ST_SLE_SRC_N;
        end
        else if (is_az)
        begin
            next_len    = LEN_ACC_ZERO; // RQ7
            next_states = az_cond ? ST_AZ_T : ST_AZ_N;
        end
    end

    // ****************************************************************
    // Execution sequencer
    // ****************************************************************
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            state  <= SJB_IDLE;
            remain <= '0;
            BUSY   <= 1'b0;
            DONE   <= 1'b0;
        end
        else if (CLK_EN)
        begin
            DONE <= 1'b0;
            unique case (state)
                SJB_IDLE:
                begin
                    if (INSN_VALID && (is_sle || is_az))
                    begin
                        if (next_states == ONE_STATE)
                            DONE <= 1'b1;
                        else
                        begin
                            state  <= SJB_BUSY;
                            BUSY   <= 1'b1;
                            remain <= next_states - ONE_STATE;
                        end
                    end
                end
                SJB_BUSY:
                begin
                    remain <= remain - ONE_STATE;
                    if (remain == ONE_STATE)
                    begin
                        state <= SJB_IDLE;
                        BUSY  <= 1'b0;
                        DONE  <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Result registers, loaded when an instruction is accepted
    // ****************************************************************
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_N)
        begin
            DECODED  <= 1'b0;
            TAKEN    <= 1'b0;
            PC_OUT   <= '0;
            INSN_LEN <= '0;
            STATES   <= '0;
            ACC_OUT  <= '0;
        end
        else if (CLK_EN && state == SJB_IDLE && INSN_VALID)
        begin
            DECODED  <= is_sle || is_az;
            TAKEN    <= next_taken;
            PC_OUT   <= next_taken ? next_target : next_pc_seq; // RQ4
            INSN_LEN <= next_len;
            STATES   <= next_states;
            ACC_OUT  <= ACC_IN; // RQ6
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic accept;
    assign accept = CLK_EN && state == SJB_IDLE && INSN_VALID;

    property p_sle_cond;
        @(posedge CORE_CLK) disable iff (!RST_N)
        accept && is_sle |=> TAKEN == $past(sle_cond);
    endproperty
    a_sle_cond: assert property (p_sle_cond) // RQ1
        else $error("signed-le taken mismatch");

    property p_sle_target;
        @(posedge CORE_CLK) disable iff (!RST_N)
        accept && is_sle && sle_cond |=>
            PC_OUT == $past(PC_IN) + PC_STEP + sext_disp($past(DISP));
    endproperty
    a_sle_target: assert property (p_sle_target) // RQ2
        else $error("signed-le target wrong");

    property p_sle_bin;
        @(posedge CORE_CLK) disable iff (!RST_N)
        accept && is_sle && !SOURCE_MODE |=> INSN_LEN == LEN_SLE_BIN
            && STATES == ($past(sle_cond) ? ST_SLE_BIN_T : ST_SLE_BIN_N);
    endproperty
    a_sle_bin: assert property (p_sle_bin) // RQ3
        else $error("binary signed-le length or states wrong");

    property p_not_taken;
        @(posedge CORE_CLK) disable iff (!RST_N)
        accept && (is_sle || is_az) && !next_taken |=>
            PC_OUT == $past(PC_IN) + PC_STEP;
    endproperty
    a_not_taken: assert property (p_not_taken) // RQ4
        else $error("not-taken PC wrong");

    property p_az_cond;
        @(posedge CORE_CLK) disable iff (!RST_N)
        accept && is_az |=> TAKEN == ($past(ACC_IN) == '0);
    endproperty
    a_az_cond: assert property (p_az_cond) // RQ5
        else $error("acc-zero taken mismatch");

    property p_acc_keep;
        @(posedge CORE_CLK) disable iff (!RST_N)
        accept && is_az |=> ACC_OUT == $past(ACC_IN);
    endproperty
    a_acc_keep: assert property (p_acc_keep) // RQ6
        else $error("accumulator altered");

    property p_az_states;
        @(posedge CORE_CLK) disable iff (!RST_N)
        accept && is_az && az_cond |=>
            BUSY [*4] ##1 DONE;
    endproperty
    a_az_states: assert property (p_az_states) // RQ7
        else $error("acc-zero taken not five states");

    property p_src_fast;
        @(posedge CORE_CLK) disable iff (!RST_N)
        accept && is_sle && SOURCE_MODE && !sle_cond |=>
            DONE && !BUSY && INSN_LEN == LEN_SLE_SRC;
    endproperty
    a_src_fast: assert property (p_src_fast) // RQ3
        else $error("source signed-le untaken not one state");

    c_sle_taken: cover property (@(posedge CORE_CLK)
        accept && is_sle && sle_cond);
    c_az_taken: cover property (@(posedge CORE_CLK)
        accept && is_az && az_cond);
    c_az_not: cover property (@(posedge CORE_CLK)
        accept && is_az && !az_cond);
endmodule : sjb_branch_unit

// file: design/sjb_pkg.sv
// Package for the signed less-or-equal / accumulator-zero branch unit.
// Assumes a 16-bit program counter and an 8-bit accumulator.
package sjb_pkg;
    // ****************************************************************
    // Widths and encodings
    // ****************************************************************
    localparam int          PC_W          = 16;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  ESCAPE_BYTE   = 8'hA5;
    localparam logic [7:0]  OPC_SIGNED_LE = 8'h08;
    localparam logic [7:0]  OPC_ACC_ZERO  = 8'h60;
    localparam logic [15:0] PC_STEP       = 16'h0002;
    // ****************************************************************
    // Instruction lengths and state counts
    // ****************************************************************
    localparam logic [1:0]  LEN_SLE_BIN   = 2'h3;
    localparam logic [1:0]  LEN_SLE_SRC   = 2'h2;
    localparam logic [1:0]  LEN_ACC_ZERO  = 2'h2;
    localparam logic [2:0]  ST_SLE_BIN_N  = 3'h2;
    localparam logic [2:0]  ST_SLE_BIN_T  = 3'h5;
    localparam logic [2:0]  ST_SLE_SRC_N  = 3'h1;
    localparam logic [2:0]  ST_SLE_SRC_T  = 3'h4;
    localparam logic [2:0]  ST_AZ_N       = 3'h2;
    localparam logic [2:0]  ST_AZ_T       = 3'h5;
    localparam logic [2:0]  ONE_STATE     = 3'h1;

    typedef enum logic [1:0]
    {
        SJB_IDLE = 2'b00,
        SJB_BUSY = 2'b01
    } sjb_state_t;
endpackage : sjb_pkg

// file: tb/tb_top.sv
// Self-checking bench for the branch unit.
// Assumes sjb_pkg is compiled first; bench drives all inputs itself.
`timescale 1ns/1ps
module tb_top;
    import sjb_pkg::*;
    logic              CORE_CLK, RST_N, CLK_EN, INSN_VALID;
    logic              SOURCE_MODE, ESCAPED, ZERO_FLAG, NEG_FLAG;
    logic              OVERFLOW_FLAG, BUSY, DONE, DECODED, TAKEN;
    logic [7:0]        OPCODE, DISP;
    logic [PC_W-1:0]   PC_IN, PC_OUT;
    logic [DATA_W-1:0] ACC_IN, ACC_OUT;
    logic [1:0]        INSN_LEN;
    logic [2:0]        STATES;
    int                num_errors, n_checks;

    sjb_branch_unit i_sjb_branch_unit (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
        .CLK_EN(CLK_EN), .INSN_VALID(INSN_VALID), .SOURCE_MODE(SOURCE_MODE),
        .ESCAPED(ESCAPED), .OPCODE(OPCODE), .DISP(DISP), .PC_IN(PC_IN),
        .ACC_IN(ACC_IN), .ZERO_FLAG(ZERO_FLAG), .NEG_FLAG(NEG_FLAG),
        .OVERFLOW_FLAG(OVERFLOW_FLAG), .BUSY(BUSY), .DONE(DONE),
        .DECODED(DECODED), .TAKEN(TAKEN), .PC_OUT(PC_OUT),
        .INSN_LEN(INSN_LEN), .STATES(STATES), .ACC_OUT(ACC_OUT));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // Offer one instruction and follow it to completion
    task automatic offer(input logic src, esc, input logic [7:0] opc, dsp,
        input logic [15:0] pc, input logic [7:0] acc, input logic z, n, v);
        logic        dec, tk, az;
        logic [2:0]  st;
        logic [1:0]  len;
        logic [15:0] tgt;
        az  = (opc == 8'h60);
        dec = (az && !esc) || (opc == 8'h08 && esc == !src);
        tk  = az ? (acc == 8'h00) : (z | (n ^ v));
        len = (!az && !src) ? 2'h3 : 2'h2;
        st  = (az || !src) ? (tk ? 3'h5 : 3'h2) : (tk ? 3'h4 : 3'h1);
        tgt = pc + 16'h0002 + (tk ? {{8{dsp[7]}}, dsp} : 16'h0000);
        {SOURCE_MODE, ESCAPED, OPCODE, DISP} = {src, esc, opc, dsp};
        {PC_IN, ACC_IN, ZERO_FLAG, NEG_FLAG, OVERFLOW_FLAG} =
            {pc, acc, z, n, v};
        // Offers seen while busy are ignored, so valid may stay high
        INSN_VALID = 1'b1;
        @(negedge CORE_CLK);
        chk("decoded", 16'(dec), 16'(DECODED));
        if (!dec)
        begin
            chk("done", 16'h0000, 16'(DONE));
            return;
        end
        chk("taken", 16'(tk), 16'(TAKEN));
        chk("pc_out", tgt, PC_OUT);
        chk("len", 16'(len), 16'(INSN_LEN));
        chk("states", 16'(st), 16'(STATES));
        if (az)
            chk("acc_out", 16'(acc), 16'(ACC_OUT));
        for (int k = 1; k <= st; k++)
        begin
            if (k > 1)
                @(negedge CORE_CLK);
            chk("done", 16'(k == st), 16'(DONE));
            chk("busy", 16'(k < st), 16'(BUSY));
        end
    endtask : offer

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic sc_signed_le;
        for (int m = 0; m < 16; m++)
            offer(m[3], !m[3], 8'h08, 8'hF0, 16'h1234, 8'h55,
                  m[2], m[1], m[0]);
    endtask : sc_signed_le

    task automatic sc_acc_zero;
        logic [7:0] av[4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
        for (int m = 0; m < 8; m++)
            offer(m[2], 1'b0, 8'h60, 8'h10, 16'h0100, av[m[1:0]],
                  1'b1, 1'b0, 1'b0);
    endtask : sc_acc_zero

    task automatic sc_disp_reach;
        offer(1'b0, 1'b0, 8'h60, 8'h80, 16'h0040, 8'h00, 0, 0, 0);
        offer(1'b0, 1'b0, 8'h60, 8'h7F, 16'hFFF0, 8'h00, 0, 0, 0);
        offer(1'b1, 1'b0, 8'h08, 8'hFF, 16'h8000, 8'h00, 1, 0, 0);
    endtask : sc_disp_reach

    task automatic sc_bad_encoding;
        offer(1'b0, 1'b0, 8'h08, 8'h01, 16'h0200, 8'h00, 1, 0, 0);
        offer(1'b1, 1'b1, 8'h08, 8'h01, 16'h0200, 8'h00, 1, 0, 0);
        offer(1'b0, 1'b1, 8'h60, 8'h01, 16'h0200, 8'h00, 0, 0, 0);
        offer(1'b1, 1'b0, 8'h18, 8'h01, 16'h0200, 8'h00, 1, 0, 0);
    endtask : sc_bad_encoding

    // Enable held low mid-sequence, then a reset in mid-run
    task automatic sc_freeze_reset;
        {SOURCE_MODE, ESCAPED, OPCODE, DISP} = {1'b0, 1'b1, 8'h08, 8'h10};
        {PC_IN, ACC_IN, ZERO_FLAG, NEG_FLAG, OVERFLOW_FLAG} =
            {16'h0300, 8'h00, 1'b1, 1'b0, 1'b0};
        INSN_VALID = 1'b1;
        @(negedge CORE_CLK);
        CLK_EN = 1'b0;
        repeat (3) @(negedge CORE_CLK);
        chk("frz_busy", 16'h0001, 16'(BUSY));
        chk("frz_done", 16'h0000, 16'(DONE));
        chk("frz_states", 16'h0005, 16'(STATES));
        CLK_EN = 1'b1;
        repeat (3) @(negedge CORE_CLK);
        chk("frz_busy4", 16'h0001, 16'(BUSY));
        @(negedge CORE_CLK);
        INSN_VALID = 1'b0;
        chk("frz_done5", 16'h0001, 16'(DONE));
        chk("frz_pc", 16'h0312, PC_OUT);
        @(negedge CORE_CLK);
        chk("done_pulse", 16'h0000, 16'(DONE));
        INSN_VALID = 1'b1;
        @(negedge CORE_CLK);
        {RST_N, INSN_VALID} = 2'b00;
        @(negedge CORE_CLK);
        chk("mid_rst_busy", 16'h0000, 16'(BUSY));
        chk("mid_rst_pc", 16'h0000, PC_OUT);
        RST_N = 1'b1;
        @(negedge CORE_CLK);
        chk("mid_rst_done", 16'h0000, 16'(DONE));
    endtask : sc_freeze_reset

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end

    initial
    begin
        num_errors = 0;
        n_checks = 0;
        {RST_N, CLK_EN, INSN_VALID, SOURCE_MODE, ESCAPED} = 5'b01000;
        {OPCODE, DISP, PC_IN, ACC_IN} = '0;
        {ZERO_FLAG, NEG_FLAG, OVERFLOW_FLAG} = 3'b000;
        repeat (5) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        RST_N = 1'b1;
        chk("rst_done", 16'h0000, 16'(DONE));
        chk("rst_pc", 16'h0000, PC_OUT);
        sc_signed_le();
        sc_acc_zero();
        sc_disp_reach();
        sc_bad_encoding();
        sc_freeze_reset();
        stop_test();
    end
endmodule : tb_top
